// File: sdr_map.svh
// Constants for the SPI default-recovery reset detector
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH
`define SDR_PULSES       3'h4
`define SDR_SR1_DEFAULT  8'h00
`define SDR_CR1_DEFAULT  8'h00
`define SDR_CR2_DEFAULT  8'h00
`define SDR_CR4_DEFAULT  8'h08
`define SDR_CR5_DEFAULT  8'h00
`define SDR_ZERO8        8'h00
`define SDR_ZERO32       32'h0000_0000
`define SDR_RESET_NS     1000
`define SDR_CLK_NS       8
`define SDR_RESET_CYC    ((`SDR_RESET_NS + `SDR_CLK_NS - 1) / `SDR_CLK_NS)
`endif

// File: sdr_pkg.sv
// Types for the SPI default-recovery reset detector
package sdr_pkg;
   typedef enum logic [1:0] {SDR_IDLE, SDR_LOW, SDR_HIGH, SDR_BUSY} sdr_phase_e;
   typedef logic [7:0] sdr_byte_t;
endpackage : sdr_pkg

// File: sdr_recovery.sv
// Default-recovery reset detector and register initialiser
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"
module sdr_recovery #(
   parameter int RESET_CYC = `SDR_RESET_CYC
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // SPI pins from the host
   input  wire logic             cs_n_pin,
   input  wire logic             io0_pin,
   // Power-state events from the command decoder
   input  wire logic             deep_sleep_mode,
   input  wire logic             hibernate_exit,
   input  wire logic             pin_reset,
   // Recovery status and register contents
   output logic                  recovery_busy,
   output logic                  recovery_done,
   output logic                  outputs_tristate,
   output sdr_pkg::sdr_byte_t    status_reg_one,
   output sdr_pkg::sdr_byte_t    status_reg_two,
   output sdr_pkg::sdr_byte_t    cfg_reg_one,
   output sdr_pkg::sdr_byte_t    cfg_reg_two,
   output sdr_pkg::sdr_byte_t    cfg_reg_four,
   output sdr_pkg::sdr_byte_t    cfg_reg_five,
   output sdr_pkg::sdr_byte_t    ecc_status_reg,
   output logic [31:0]           crc_reg,
   output sdr_pkg::sdr_byte_t    ecc_error_count_reg,
   output logic [31:0]           ecc_error_address_reg
);
   import sdr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State fields, all held in one packed record
   // cs_m, cs_s     - two-stage synchroniser for chip select
   // cs_d           - previous synchronised chip select, for edges
   // io_m, io_s     - two-stage synchroniser for IO0
   // phase          - where the pattern tracker stands
   // pulses         - valid pulses seen so far in this pattern
   // last_io        - IO0 level latched at the last chip-select fall
   // wait_cnt       - cycles left in the internal reset wait
   // done           - one-cycle pulse when the reset wait ends
   // sr1 .. eadr    - register images driven to the outputs
   // Serial clock and IO1 to IO3 never reach this block, so
   // a bus-width setting cannot disturb the pattern tracking.
   typedef struct packed {
      logic       cs_m;
      logic       cs_s;
      logic       cs_d;
      logic       io_m;
      logic       io_s;
      sdr_phase_e phase;
      logic [2:0] pulses;
      logic       last_io;
      logic [15:0] wait_cnt;
      logic       done;
      sdr_byte_t  sr1;
      sdr_byte_t  sr2;
      sdr_byte_t  cr1;
      sdr_byte_t  cr2;
      sdr_byte_t  cr4;
      sdr_byte_t  cr5;
      sdr_byte_t  eccs;
      logic [31:0] crc;
      sdr_byte_t  ecnt;
      logic [31:0] eadr;
   } sdr_state_s;

   sdr_state_s st_reg;
   sdr_state_s st_next;

   // Full default load, shared by hibernate exit, pin reset and recovery
   function automatic sdr_state_s sdr_defaults(input sdr_state_s s);
      sdr_state_s r;
      r      = s;
      r.sr1  = `SDR_SR1_DEFAULT;
      r.sr2  = `SDR_ZERO8;
      r.cr1  = `SDR_CR1_DEFAULT;
      r.cr2  = `SDR_CR2_DEFAULT;
      r.cr4  = `SDR_CR4_DEFAULT;
      r.cr5  = `SDR_CR5_DEFAULT;
      r.eccs = `SDR_ZERO8;
      r.crc  = `SDR_ZERO32;
      r.ecnt = `SDR_ZERO8;
      r.eadr = `SDR_ZERO32;
      return r;
   endfunction : sdr_defaults

   logic cs_fall;
   logic cs_rise;
   assign cs_fall = st_reg.cs_d & ~st_reg.cs_s;
   assign cs_rise = ~st_reg.cs_d & st_reg.cs_s;

   ////////////////////////////////////////////////////////////////////////
   // Pattern walk, as the tracker sees it
   // Idle: waits for a chip-select fall, latches IO0, counts one
   // Low: IO0 must hold until chip select rises again
   // High: next fall must show IO0 inverted, else count restarts at one
   // Fourth clean rise: enter the reset wait and force defaults
   // Both pins cross the same synchroniser depth, so a host that moves
   // them together is seen moving them in the same cycle.
   // Limitation: IO0 landing a clock edge after chip select at the
   // fall reads as a bad pulse; the host then simply repeats the pattern.
   // Chip-select activity during the reset wait is ignored on purpose,
   // so a host that keeps toggling cannot stretch or restart the wait.
   // Next state: pattern tracking, only chip select and IO0 are heard
   always_comb
   begin
      st_next      = st_reg;
      st_next.cs_m = cs_n_pin;
      st_next.cs_s = st_reg.cs_m;
      st_next.cs_d = st_reg.cs_s;
      st_next.io_m = io0_pin;
      st_next.io_s = st_reg.io_m;
      st_next.done = 1'b0;
      unique case (st_reg.phase)
         SDR_IDLE, SDR_HIGH:
         begin
            // Any mode: pattern does not depend on bus width
            if (cs_fall)
            begin
               // Each fall must invert IO0 versus the previous
               if (st_reg.phase == SDR_HIGH && st_reg.io_s != st_reg.last_io)
                  st_next.pulses = st_reg.pulses + 3'h1;
               else
                  st_next.pulses = 3'h1;
               st_next.last_io = st_reg.io_s;
               st_next.phase   = SDR_LOW;
            end
         end
         SDR_LOW:
         begin
            if (cs_rise)
            begin
               // IO0 held during the low phase, else restart
               if (st_reg.io_s != st_reg.last_io)
                  st_next.phase = SDR_IDLE;
               else if (st_reg.pulses == `SDR_PULSES)
               begin
                  // Reset begins on the fourth rise
                  st_next.phase    = SDR_BUSY;
                  st_next.wait_cnt = 16'(RESET_CYC);
               end
               else
                  st_next.phase = SDR_HIGH;
            end
            else if (st_reg.io_s != st_reg.last_io)
               st_next.phase = SDR_IDLE; // Bad pulse
         end
         SDR_BUSY:
         begin
            // Defaults and zeroes, all register images
            st_next = sdr_defaults(st_next);
            if (st_reg.wait_cnt <= 16'h0001)
            begin
               st_next.phase  = SDR_IDLE;
               st_next.pulses = 3'h0;
               st_next.done   = 1'b1; // Hung device restored
            end
            else
               st_next.wait_cnt = st_reg.wait_cnt - 16'h0001;
         end
      endcase
      // Deep sleep drops ECC error records
      if (deep_sleep_mode)
      begin
         st_next.ecnt = `SDR_ZERO8;
         st_next.eadr = `SDR_ZERO32;
      end
      // Hibernate exit and pin reset reload power-up values
      if (hibernate_exit || pin_reset)
         st_next = sdr_defaults(st_next); // Registers only, phase and wait kept
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; power-up values are the same defaults
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_reg          <= '0;
         st_reg.cs_m     <= 1'b1;
         st_reg.cs_s     <= 1'b1;
         st_reg.cs_d     <= 1'b1;
         st_reg.phase    <= SDR_IDLE;
         st_reg.cr4      <= `SDR_CR4_DEFAULT;
         st_reg.sr1      <= `SDR_SR1_DEFAULT;
         st_reg.cr1      <= `SDR_CR1_DEFAULT;
         st_reg.cr2      <= `SDR_CR2_DEFAULT;
         st_reg.cr5      <= `SDR_CR5_DEFAULT;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; tristate while a pattern is under way or reset runs
   assign recovery_busy    = (st_reg.phase == SDR_BUSY);
   assign outputs_tristate = (st_reg.phase != SDR_IDLE);
   assign recovery_done         = st_reg.done;
   assign status_reg_one        = st_reg.sr1;
   assign status_reg_two        = st_reg.sr2;
   assign cfg_reg_one           = st_reg.cr1;
   assign cfg_reg_two           = st_reg.cr2;
   assign cfg_reg_four          = st_reg.cr4;
   assign cfg_reg_five          = st_reg.cr5;
   assign ecc_status_reg        = st_reg.eccs;
   assign crc_reg               = st_reg.crc;
   assign ecc_error_count_reg   = st_reg.ecnt;
   assign ecc_error_address_reg = st_reg.eadr;
endmodule : sdr_recovery
`default_nettype wire

// File: sdr_recovery_props.sv
// Checker for the recovery reset detector
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"
module sdr_recovery_props #(
   parameter int RESET_CYC = 4
) (
   // Clock, reset, pins and events
   input wire logic clk_sys, rst, cs_n_pin,
   input wire logic deep_sleep_mode, hibernate_exit, pin_reset,
   input wire logic recovery_busy, recovery_done, outputs_tristate,
   // Register images
   input wire sdr_pkg::sdr_byte_t status_reg_one, status_reg_two,
   input wire sdr_pkg::sdr_byte_t cfg_reg_one, cfg_reg_two, cfg_reg_four,
   input wire sdr_pkg::sdr_byte_t cfg_reg_five, ecc_status_reg,
   input wire sdr_pkg::sdr_byte_t ecc_error_count_reg,
   input wire logic [31:0] crc_reg, ecc_error_address_reg
);
   import sdr_pkg::*;
   logic [7:0] busy_cnt_reg;
   // All images at defaults
   wire logic dflt = {status_reg_one, status_reg_two, cfg_reg_one,
      cfg_reg_two, cfg_reg_four, cfg_reg_five, ecc_status_reg,
      ecc_error_count_reg, crc_reg, ecc_error_address_reg} ==
      {`SDR_SR1_DEFAULT, `SDR_ZERO8, `SDR_CR1_DEFAULT, `SDR_CR2_DEFAULT,
      `SDR_CR4_DEFAULT, `SDR_CR5_DEFAULT, `SDR_ZERO8, `SDR_ZERO8,
      `SDR_ZERO32, `SDR_ZERO32};
   // Counts busy cycles; too long for a repetition
   always_ff @(posedge clk_sys or posedge rst)
      if (rst) busy_cnt_reg <= 8'h00;
      else busy_cnt_reg <= recovery_busy ? busy_cnt_reg + 8'h01 : 8'h00;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_busy_len:
   assert property ($fell(recovery_busy) |-> busy_cnt_reg == RESET_CYC)
      else $error("busy held wrong length");
   a_busy_cause:
   assert property ($rose(recovery_busy) |-> cs_n_pin && $past(cs_n_pin, 3))
      else $error("busy without chip select high");
   a_done_end:
   assert property (recovery_done |-> $past(recovery_busy) && !recovery_busy)
      else $error("done not at end of busy");
   a_busy_dflt:
   assert property (recovery_busy |=> dflt) else $error("no defaults");
   a_sleep_clr:
   assert property (deep_sleep_mode |=> ecc_error_count_reg == 8'h00 &&
      ecc_error_address_reg == 32'h0000_0000) else $error("ecc kept");
   a_hib_load:
   assert property (hibernate_exit |=> dflt) else $error("hib no reload");
   a_pin_load:
   assert property (pin_reset |=> dflt) else $error("pin no reload");
   a_busy_tri:
   assert property (recovery_busy |-> outputs_tristate)
      else $error("outputs driven in reset");
   c_busy: cover property ($rose(recovery_busy));
   c_done: cover property (recovery_done);
   c_hib: cover property (hibernate_exit);
endmodule : sdr_recovery_props
bind sdr_recovery sdr_recovery_props #(.RESET_CYC(RESET_CYC)) i_props (.*);
`default_nettype wire

// File: sdr_host_model.sv
// SPI host model playing the recovery pattern
`timescale 1ns/1ns
`default_nettype none
module sdr_host_model (
   // Host pins
   input  wire logic clk_sys,
   output logic      cs_n,
   output logic      io0,
   output logic      sck
);
   // Serial clock parked for the whole run
   initial {cs_n, io0, sck} = 3'b100;
   // One pulse per pass; glitch moves IO0 while selected
   task automatic pulses(input int n, input logic lvl, glitch);
      repeat (n)
      begin
         @(posedge clk_sys);
         cs_n <= 1'b0;
         io0 <= lvl;
         repeat (4) @(posedge clk_sys);
         if (glitch) io0 <= ~lvl;
         repeat (4) @(posedge clk_sys);
         cs_n <= 1'b1;
         repeat (3) @(posedge clk_sys);
         lvl = ~lvl;
      end
   endtask : pulses
endmodule : sdr_host_model
`default_nettype wire

// File: sdr_recovery_tb.sv
// Testbench for the recovery reset detector
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"
module sdr_recovery_tb;
   import sdr_pkg::*;
   logic      clk_sys = 0, rst = 1;
   logic      cs_n, io0, sck, busy, done, tri_on;
   logic [2:0] ev = 3'b000;
   sdr_byte_t sr1, sr2, c1, c2, c4, c5, ecs, ecnt;
   logic [31:0] crc, eadr;
   int        n_errors = 0, cmp_count = 0;
   wire logic [127:0] regs = {sr1, sr2, c1, c2, c4, c5, ecs, ecnt, crc, eadr};
   localparam logic [127:0] DEF = {`SDR_SR1_DEFAULT, `SDR_ZERO8,
      `SDR_CR1_DEFAULT, `SDR_CR2_DEFAULT, `SDR_CR4_DEFAULT,
      `SDR_CR5_DEFAULT, `SDR_ZERO8, `SDR_ZERO8, `SDR_ZERO32, `SDR_ZERO32};
   always #4 clk_sys = ~clk_sys;
   // Short reset wait keeps the run brief
   sdr_recovery #(.RESET_CYC(4)) i_sdr_recovery (.clk_sys(clk_sys),
      .rst(rst), .cs_n_pin(cs_n), .io0_pin(io0), .deep_sleep_mode(ev[2]),
      .hibernate_exit(ev[1]), .pin_reset(ev[0]), .recovery_busy(busy),
      .recovery_done(done), .outputs_tristate(tri_on),
      .status_reg_one(sr1), .status_reg_two(sr2), .cfg_reg_one(c1),
      .cfg_reg_two(c2), .cfg_reg_four(c4), .cfg_reg_five(c5),
      .ecc_status_reg(ecs), .crc_reg(crc), .ecc_error_count_reg(ecnt),
      .ecc_error_address_reg(eadr));
   sdr_host_model i_sdr_host_model (.clk_sys(clk_sys), .cs_n(cs_n),
      .io0(io0), .sck(sck));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [127:0] exp, got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // Waits are bounded so a dead detector cannot hang the run
   task run(input string nm, input int n, input logic lvl, gl, want);
      int k;
      i_sdr_host_model.pulses(n, lvl, gl);
      for (k = 0; k < 12 && busy !== 1'b1; k++) @(posedge clk_sys) #1;
      chk({nm, " busy"}, want, busy);
      if (want)
      begin
         chk({nm, " tristate"}, 1, tri_on);
         for (k = 0; k < 12 && done !== 1'b1; k++) @(posedge clk_sys) #1;
         chk({nm, " done"}, 1, done);
         chk({nm, " released"}, 0, tri_on);
         chk({nm, " regs"}, DEF, regs);
      end
      $display("test %s ended", nm);
   endtask : run
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      #1 chk("reset regs", DEF, regs);
      run("start low", 4, 0, 0, 1);
      run("start high", 4, 1, 0, 1);
      run("three only", 3, 0, 0, 0);
      run("glitch", 4, 0, 1, 0);
      run("recover", 4, 1, 0, 1);
      // Deep sleep, hibernate exit, pin reset in turn
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys) ev <= 3'b100 >> i;
         repeat (2) @(posedge clk_sys);
         #1 chk("power event", DEF, regs);
         @(posedge clk_sys) ev <= 3'b000;
      end
      $display("test power events ended");
      conclude;
   end
   initial
   begin
      #40000 n_errors++;
      conclude;
   end
endmodule : sdr_recovery_tb
`default_nettype wire
